/* File: rtl/mwd_consts.svh */
// Field positions and codes of the microword field decoder
`ifndef MWD_CONSTS_SVH
`define MWD_CONSTS_SVH
// ====================================================================
// Opcode values at bits 22:19
`define MWD_OP_MEMREQ   4'h3
`define MWD_OP_MISCPORT 4'h2
`define MWD_OP_JUMP     4'h1
`define MWD_OP_DECODE   4'h0
// ====================================================================
// Port device, operations and special codes
`define MWD_DEV_DISK    3'h7
`define MWD_PORT_READ   2'h0
`define MWD_PORT_WRITE  2'h1
`define MWD_PORT_CTRL   2'h2
`define MWD_M1_NOP      4'hF
`define MWD_NAT_RDMODE  4'h5
`define MWD_CM_RDMODE   4'h0
// ====================================================================
// Wishbone register offsets (byte addresses)
`define MWD_ADR_WORD    4'h0
`define MWD_ADR_CTRL    4'h4
`define MWD_ADR_FLAGS   4'h8
`define MWD_ADR_ACT     4'hC
// ====================================================================
// Reset values
`define MWD_WORD_RST    24'h800000
`endif

/* File: rtl/mwd_pkg.sv */
// Types shared by the microword field decoder
package mwd_pkg;
  typedef enum logic [4:0] {
    MWD_T_OTHER   = 5'h01,
    MWD_T_MEMREQ  = 5'h02,
    MWD_T_MISC    = 5'h04,
    MWD_T_JUMP    = 5'h08,
    MWD_T_DECODE  = 5'h10
  } mwd_type_e;

  // Sequencer condition inputs
  typedef struct packed {
    logic alu_n;
    logic alu_z;
    logic alu_v;
    logic alu_c;
    logic processor_status_carry;
    logic branch_false;
    logic general_register_destination;
    logic interrupt_request;
    logic error_summary;
    logic accelerator_sync;
    logic port_interrupt;
    logic instruction_buffer_valid;
    logic compat_mode;
  } mwd_cond_s;

  // Sequencer directives
  typedef struct packed {
    logic        jump;
    logic        call;
    logic        skip;
    logic        ret;
    logic        ret_plus1;
    logic        pop;
    logic        loop;
    logic [13:0] target;
  } mwd_seq_s;

  // Port bus command
  typedef struct packed {
    logic       valid;
    logic [2:0] device;
    logic [1:0] op;
    logic [2:0] hw_sel;
    logic       disk_controller;
  } mwd_port_s;
endpackage

/* File: rtl/mwd_decoder.sv */
// Microword field decoder with Wishbone-visible state
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mwd_consts.svh"

module mwd_decoder
  import mwd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        word_load_i,
  input  wire logic [23:0] word_i,
  input  wire mwd_cond_s   cond_i,
  input  wire logic [7:0]  instruction_bus_i,
  output mwd_seq_s         seq_o,
  output mwd_port_s        port_o,
  output logic [4:0]       micro_type_o,
  output logic             parity_error_o,
  output logic             misc_strobes_valid_o,
  output logic [6:0]       misc_strobes_o,
  output logic [4:0]       flags_o,
  output logic [1:0]       console_o,
  output logic [4:0]       operand_specifier_register_o,
  output logic             register_destination_flag_o,
  output logic [4:0]       memory_function_field_o,
  output logic [1:0]       operand_size_field_o,
  output logic [6:0]       local_store_select_field_o,
  output logic             working_reg_sel_o,
  output logic [2:0]       pc_store_wr_o,
  output logic [5:0]       mapping_rom_addr_hi_o,
  output logic             mapping_rom_select_o,
  output logic             instruction_byte_request_o,
  output logic             compat_high_byte_select_o
);

  // ==================================================================
  // Current microword and field functions
  logic [23:0] current_microword_register_r;
  logic        exec_r;

  function automatic logic cond_test(input logic [2:0] c,
                                     input mwd_cond_s k);
    case (c)
      3'h0:    cond_test = ~k.alu_n;
      3'h1:    cond_test = ~k.alu_z;
      3'h2:    cond_test = ~k.alu_v;
      3'h3:    cond_test = k.alu_c;
      3'h5:    cond_test = k.branch_false;
      3'h6:    cond_test = k.general_register_destination;
      3'h7:    cond_test = ~k.interrupt_request;
      default: cond_test = 1'b0;
    endcase
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_microword_register_r <= `MWD_WORD_RST;
      exec_r                       <= 1'b0;
    end else begin
      exec_r <= word_load_i;
      if (word_load_i) begin
        current_microword_register_r <= word_i;
      end
    end
  end

  logic [23:0] w;
  logic [3:0]  op4;
  mwd_type_e   typ;
  assign w   = current_microword_register_r;
  assign op4 = w[22:19];

  always_comb begin
    if (w[22] || w[21]) begin
      typ = MWD_T_OTHER;
    end else begin
      case (op4)
        `MWD_OP_MEMREQ:   typ = MWD_T_MEMREQ;
        `MWD_OP_MISCPORT: typ = MWD_T_MISC;
        `MWD_OP_JUMP:     typ = MWD_T_JUMP;
        `MWD_OP_DECODE:   typ = MWD_T_DECODE;
        default:          typ = MWD_T_OTHER;
      endcase
    end
  end

  logic is_misc;
  logic is_port;
  assign is_misc = exec_r && typ == MWD_T_MISC && !w[18];
  assign is_port = exec_r && typ == MWD_T_MISC && w[18];

  // ==================================================================
  // Flags: A, B, backup, accelerator select, store page, console
  logic flag_a_r;
  logic flag_b_r;
  logic backup_flag_r;
  logic accelerator_input_select_r;
  logic writable_store_page_r;
  logic console_attention_r;
  logic console_ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_a_r                   <= 1'b0;
      flag_b_r                   <= 1'b0;
      backup_flag_r              <= 1'b0;
      accelerator_input_select_r <= 1'b0;
      writable_store_page_r      <= 1'b0;
      console_attention_r        <= 1'b0;
      console_ack_r              <= 1'b0;
    end else if (is_misc) begin
      case (w[15:12])
        4'h0: begin flag_b_r <= 1'b0; flag_a_r <= 1'b0; end
        4'h1: begin flag_b_r <= 1'b0; flag_a_r <= 1'b1; end
        4'h2: begin flag_b_r <= 1'b1; flag_a_r <= 1'b0; end
        4'h3: flag_a_r <= 1'b0;
        4'h4: flag_b_r <= 1'b0;
        4'h5: flag_a_r <= 1'b1;
        4'h6: flag_b_r <= 1'b1;
        4'h7: backup_flag_r <= 1'b1;
        4'h8: accelerator_input_select_r <= 1'b1;
        4'h9: accelerator_input_select_r <= 1'b0;
        4'hA: writable_store_page_r <= 1'b0;
        4'hB: writable_store_page_r <= 1'b1;
        4'hC: begin
          console_attention_r <= 1'b0;
          console_ack_r       <= 1'b0;
        end
        4'hD: console_ack_r <= 1'b1;
        4'hE: console_attention_r <= 1'b1;
        default: ;
      endcase
    end
  end

  // ==================================================================
  // Second misc strobes, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      misc_strobes_o       <= 7'h00;
      misc_strobes_valid_o <= 1'b0;
    end else begin
      misc_strobes_valid_o <= is_misc;
      misc_strobes_o       <= 7'h00;
      if (is_misc && w[11:9] != 3'h0) begin
        misc_strobes_o[w[11:9] - 3'h1] <= 1'b1;
      end
    end
  end

  // ==================================================================
  // Port bus command
  logic port_ok;
  always_comb begin
    case (w[14:13])
      `MWD_PORT_READ, `MWD_PORT_WRITE: port_ok = w[12:10] <= 3'h5;
      `MWD_PORT_CTRL:                  port_ok = w[12:10] <= 3'h6;
      default:                         port_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_o <= '0;
    end else begin
      port_o.valid           <= is_port && port_ok;
      port_o.device          <= w[17:15];
      port_o.op              <= w[14:13];
      port_o.hw_sel          <= w[12:10];
      port_o.disk_controller <= w[17:15] == `MWD_DEV_DISK;
    end
  end

  // ==================================================================
  // Operand specifier and destination flag
  logic [3:0] mode_spec;
  logic       register_destination_flag_hit;
  assign mode_spec = instruction_bus_i[7:4];
  assign register_destination_flag_hit = cond_i.compat_mode ? (mode_spec == `MWD_CM_RDMODE)
                                        : (mode_spec == `MWD_NAT_RDMODE);
  logic is_dec;
  assign is_dec = exec_r && typ == MWD_T_DECODE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand_specifier_register_o <= 5'h00;
    end else if (is_dec && w[6]) begin
      operand_specifier_register_o <= instruction_bus_i[4:0];
      if (cond_i.compat_mode && w[5]) begin
        operand_specifier_register_o[3] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      register_destination_flag_o <= 1'b0;
    end else if (is_dec && w[5]) begin
      register_destination_flag_o <= register_destination_flag_hit;
    end
  end

  // ==================================================================
  // Sequencer directives
  mwd_seq_s seq_nxt;
  logic     sk;
  logic     jc;

  always_comb begin
    seq_nxt = '0;
    sk      = 1'b0;
    case (w[4:0])
      5'h04: sk = ~cond_i.processor_status_carry;
      5'h0C: sk = flag_a_r;
      5'h0D: sk = flag_b_r;
      5'h0E: sk = ~flag_a_r;
      5'h0F: sk = ~flag_b_r;
      5'h10: seq_nxt.ret_plus1 = ~cond_i.error_summary;
      5'h11: seq_nxt.loop = ~cond_i.alu_z;
      5'h12: seq_nxt.pop = 1'b1;
      5'h13: seq_nxt.loop = cond_i.alu_c;
      5'h14: seq_nxt.ret = 1'b1;
      5'h15: ;
      5'h16: seq_nxt.ret_plus1 = 1'b1;
      5'h17: seq_nxt.loop = ~cond_i.interrupt_request
                            & ~cond_i.accelerator_sync;
      5'h18: sk = console_attention_r;
      5'h19: sk = console_ack_r;
      5'h1A: sk = cond_i.port_interrupt;
      5'h1B: sk = backup_flag_r;
      5'h1C: sk = cond_i.alu_n ^ cond_i.alu_v;
      5'h1D: sk = ~cond_i.error_summary;
      5'h1E: sk = 1'b1;
      5'h1F: sk = cond_i.accelerator_sync;
      default: sk = cond_test(w[2:0], cond_i) ^ w[3];
    endcase
    jc = 1'b0;
    case (w[3:0])
      4'h4: seq_nxt.jump = 1'b1;
      4'hC: seq_nxt.call = 1'b1;
      4'hD: seq_nxt.call = cond_i.instruction_buffer_valid;
      4'hE: jc = 1'b0;
      4'hF: seq_nxt.jump = cond_i.instruction_buffer_valid;
      default: seq_nxt.jump = cond_test(w[2:0], cond_i) ^ w[3];
    endcase
    if (typ == MWD_T_JUMP) begin
      seq_nxt.target = w[17:4];
      if (w[18]) begin
        seq_nxt.target[4:0] = w[8:4] | operand_specifier_register_o;
      end
      seq_nxt.skip = (w[3:0] == 4'hE) & cond_i.instruction_buffer_valid;
    end else if (typ == MWD_T_DECODE) begin
      seq_nxt.target = {w[17:12], 8'h00};
      seq_nxt.skip = (w[3:0] == 4'hE) & cond_i.instruction_buffer_valid;
    end else begin
      seq_nxt.jump = 1'b0;
      seq_nxt.call = 1'b0;
      seq_nxt.skip = sk | jc;
    end
    if (!exec_r || typ == MWD_T_OTHER) begin
      seq_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_o <= '0;
    end else begin
      seq_o <= seq_nxt;
    end
  end

  // ==================================================================
  // Field outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      micro_type_o               <= MWD_T_OTHER;
      parity_error_o             <= 1'b0;
      memory_function_field_o    <= 5'h00;
      operand_size_field_o       <= 2'h0;
      local_store_select_field_o <= 7'h00;
      working_reg_sel_o          <= 1'b0;
      pc_store_wr_o              <= 3'h0;
      mapping_rom_addr_hi_o      <= 6'h00;
      mapping_rom_select_o       <= 1'b0;
      instruction_byte_request_o <= 1'b0;
      compat_high_byte_select_o  <= 1'b0;
    end else begin
      micro_type_o   <= typ;
      parity_error_o <= exec_r && !(^w);
      memory_function_field_o <= {w[18:16], w[8:7]};
      operand_size_field_o    <= w[6:5];
      local_store_select_field_o <= w[15:9];
      working_reg_sel_o <= w[7];
      pc_store_wr_o <= (is_dec && !w[18])
                       ? {w[9], 2'b01} : 3'h0;
      mapping_rom_addr_hi_o <= {w[4], 2'b00, w[11:9]};
      mapping_rom_select_o  <= w[4];
      instruction_byte_request_o <= is_dec && w[8];
      compat_high_byte_select_o  <= is_dec && w[7];
    end
  end

  // ==================================================================
  // Flag and console outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_o   <= 5'h00;
      console_o <= 2'h0;
    end else begin
      flags_o   <= {writable_store_page_r, accelerator_input_select_r,
                    backup_flag_r, flag_b_r, flag_a_r};
      console_o <= {console_ack_r, console_attention_r};
    end
  end

  // ==================================================================
  // Wishbone slave, one wait state, read only
  logic [31:0] rd_nxt;
  always_comb begin
    case (wb_adr_i)
      `MWD_ADR_WORD:  rd_nxt = {8'h00, w};
      `MWD_ADR_CTRL:  rd_nxt = {26'h0, exec_r, typ};
      `MWD_ADR_FLAGS: rd_nxt = {25'h0, console_ack_r, console_attention_r,
                                writable_store_page_r,
                                accelerator_input_select_r,
                                backup_flag_r, flag_b_r, flag_a_r};
      `MWD_ADR_ACT:   rd_nxt = {27'h0, operand_specifier_register_o};
      default:        rd_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: testbench/mwd_decoder_monitor.sv */
// Port checker for the microword field decoder
`timescale 1ns/1ps
`default_nettype none
module mwd_decoder_monitor
  import mwd_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        word_load_i,
  input wire logic [23:0] word_i,
  input wire mwd_seq_s    seq_o,
  input wire mwd_port_s   port_o,
  input wire logic [4:0]  micro_type_o,
  input wire logic        parity_error_o,
  input wire logic        misc_strobes_valid_o,
  input wire logic [6:0]  misc_strobes_o,
  input wire logic [4:0]  flags_o,
  input wire logic [2:0]  pc_store_wr_o,
  input wire logic [5:0]  mapping_rom_addr_hi_o
);
  // ====================================================================
  // Word taken two sample points back, flags one later
  logic [2:0]  ld_r;
  logic [23:0] w1_r;
  logic [23:0] w2_r;
  logic [23:0] w3_r;
  logic        ex;
  logic        fx;
  logic        prt;
  logic [3:0]  op;
  logic [2:0]  m2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ld_r <= 3'h0;
    end else begin
      ld_r <= {ld_r[1:0], word_load_i};
    end
  end
  always_ff @(posedge clk_i) begin
    w1_r <= word_i;
    w2_r <= w1_r;
    w3_r <= w2_r;
  end
  assign ex  = ld_r[1];
  assign fx  = ld_r[2];
  assign op  = w2_r[22:19];
  assign m2  = w2_r[11:9];
  assign prt = ex && op == 4'h2 && w2_r[18];
  // ====================================================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_type_onehot: assert property (
    ex |-> micro_type_o == (op > 4'h3 ? 5'h01 : 5'h02 << (4'h3 - op)))
    else $error("type flag does not match opcode");
  a_parity_odd: assert property (
    ex |-> parity_error_o == ~^w2_r) else $error("parity flag wrong");
  a_misc_strobe: assert property (
    ex && op == 4'h2 && !w2_r[18] |-> misc_strobes_valid_o
    && misc_strobes_o == (m2 == 3'h0 ? 7'h00 : 7'h01 << (m2 - 3'h1)))
    else $error("misc strobe wrong");
  a_flag_a_set: assert property (
    fx && w3_r[22:18] == 5'h04 && w3_r[15:12] == 4'h5 |-> flags_o[0])
    else $error("flag A not set");
  a_port_fields: assert property (
    prt && w2_r[14:13] != 2'h3 && w2_r[12:10] < 3'h4 |-> port_o.valid
    && port_o.device == w2_r[17:15] && port_o.op == w2_r[14:13]
    && port_o.disk_controller == (w2_r[17:15] == 3'h7))
    else $error("port command wrong");
  a_port_quiet: assert property (
    ex && (!prt || w2_r[14:13] == 2'h3) |-> !port_o.valid)
    else $error("port command without cause");
  a_jump_target: assert property (
    ex && op == 4'h1 && !w2_r[18] && w2_r[3:0] == 4'h4 |-> seq_o.jump
    && seq_o.target == w2_r[17:4]) else $error("jump wrong");
  a_pc_store: assert property (
    ex && op == 4'h0 |-> pc_store_wr_o ==
    (w2_r[18] ? 3'h0 : (w2_r[9] ? 3'h5 : 3'h1)))
    else $error("pc store wrong");
  a_rom_address: assert property (
    ex && op == 4'h0 |-> mapping_rom_addr_hi_o == {w2_r[4], 2'h0, m2})
    else $error("mapping address wrong");
  a_ack_follows: assert property ( // bus handshake
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_single: assert property ( // bus handshake
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  c_memreq: cover property (ex && op == 4'h3);
  c_port: cover property (port_o.valid && port_o.disk_controller);
  c_call: cover property (seq_o.call);
endmodule

bind mwd_decoder mwd_decoder_monitor mwd_decoder_monitor_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .word_load_i(word_load_i), .word_i(word_i),
  .seq_o(seq_o), .port_o(port_o), .micro_type_o(micro_type_o),
  .parity_error_o(parity_error_o), .flags_o(flags_o),
  .misc_strobes_valid_o(misc_strobes_valid_o), .misc_strobes_o(misc_strobes_o),
  .pc_store_wr_o(pc_store_wr_o), .mapping_rom_addr_hi_o(mapping_rom_addr_hi_o)
);
`default_nettype wire

/* File: testbench/mwd_far_side.sv */
// Far-side model: condition sources and disk port listener
`timescale 1ns/1ps
`default_nettype none
module mwd_far_side
  import mwd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire mwd_cond_s  cond_set_i,
  input  wire logic [7:0] ib_set_i,
  input  wire mwd_port_s  port_i,
  output var mwd_cond_s   cond_o,
  output logic [7:0]      ib_o,
  output logic [7:0]      disk_cnt_o
);
  // Condition levels change just after an edge
  always_ff @(posedge clk_i) begin
    cond_o <= cond_set_i;
    ib_o   <= ib_set_i;
  end
  // Disk controller commands seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disk_cnt_o <= 8'h00;
    end else if (port_i.valid && port_i.disk_controller) begin
      disk_cnt_o <= disk_cnt_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/mwd_decoder_tb.sv */
// Self-checking bench of the microword field decoder
`timescale 1ns/1ps
`default_nettype none
module mwd_decoder_tb
  import mwd_pkg::*;
;
  logic        clk_i;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        word_load_i = 1'b0;
  logic [23:0] word_i = 24'h0;
  mwd_cond_s   cond_i, cond_set = '0;
  logic [7:0]  ib, ib_set = 8'h00, disk_cnt;
  mwd_seq_s    seq_o;
  mwd_port_s   port_o;
  logic [4:0]  micro_type_o, flags_o;
  logic [1:0]  console_o, size_o;
  logic [2:0]  pc_o;
  logic [4:0]  mf_o, os_o;
  logic [6:0]  ms_o, ls_o;
  logic [5:0]  rom_o;
  logic        perr_o, msv_o, wr_sel_o, ibr_o, rd_o, mrs_o, chb_o;
  int          error_cnt = 0, checks_done = 0, cycles = 0;
  mwd_decoder mwd_decoder_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .word_load_i(word_load_i), .word_i(word_i), .cond_i(cond_i),
    .instruction_bus_i(ib), .seq_o(seq_o), .port_o(port_o),
    .micro_type_o(micro_type_o), .parity_error_o(perr_o),
    .misc_strobes_valid_o(msv_o), .misc_strobes_o(ms_o), .flags_o(flags_o),
    .console_o(console_o), .operand_specifier_register_o(os_o),
    .register_destination_flag_o(rd_o), .memory_function_field_o(mf_o),
    .operand_size_field_o(size_o), .local_store_select_field_o(ls_o),
    .working_reg_sel_o(wr_sel_o), .pc_store_wr_o(pc_o),
    .mapping_rom_addr_hi_o(rom_o), .mapping_rom_select_o(mrs_o),
    .instruction_byte_request_o(ibr_o), .compat_high_byte_select_o(chb_o));
  mwd_far_side mwd_far_side_i (.clk_i(clk_i), .rst_i(rst_i),
    .cond_set_i(cond_set), .ib_set_i(ib_set), .port_i(port_o),
    .cond_o(cond_i), .ib_o(ib), .disk_cnt_o(disk_cnt));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ====================================================================
  // Bus, load and compare helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Odd parity in bit 23, bad flips it
  task automatic ld(input logic [22:0] w, input logic bad = 1'b0);
    @(posedge clk_i);
    word_load_i <= 1'b1;
    word_i      <= {~^w ^ bad, w};
    @(posedge clk_i);
    word_load_i <= 1'b0;
    // Returns while the one-cycle outputs stand
    @(posedge clk_i);
    #1;
  endtask
  task automatic results();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ====================================================================
  // Scenarios
  task automatic t_memreq();
    logic [4:0] sc[7] = '{5'h00, 5'h10, 5'h12, 5'h14, 5'h15, 5'h16, 5'h1D};
    logic [3:0] ex[7] = '{4'h8, 4'h2, 4'h1, 4'h4, 4'h0, 4'h2, 4'h8};
    for (int i = 0; i < 7; i++) begin
      ld({4'h3, 3'h5, 7'h2A, 2'h1, i[1:0], sc[i]}, i[0]);
      chk(micro_type_o, 5'h02);
      chk({mf_o, size_o}, {3'h5, 2'h1, i[1:0]});
      chk(ls_o, 7'h2A);
      chk(perr_o, i[0]);
      chk({seq_o.skip, seq_o.ret, seq_o.ret_plus1, seq_o.pop},
          ex[i]);
    end
  endtask
  task automatic t_misc();
    logic [4:0]  fl = 5'h0;
    logic [1:0]  cn = 2'h0;
    logic [3:0]  m;
    logic [31:0] q;
    for (int n = 0; n < 32; n++) begin
      m = (n < 16) ? n[3:0] : 4'(31 - n);
      ld({4'h2, 3'h0, m, m[2:0], 1'b0, m[0], 7'h15});
      case (m)
        4'h0: fl[1:0] = 2'b00;
        4'h1: fl[1:0] = 2'b01;
        4'h2: fl[1:0] = 2'b10;
        4'h3: fl[0] = 1'b0;
        4'h4: fl[1] = 1'b0;
        4'h5: fl[0] = 1'b1;
        4'h6: fl[1] = 1'b1;
        4'h7: fl[2] = 1'b1;
        4'h8: fl[3] = 1'b1;
        4'h9: fl[3] = 1'b0;
        4'hA: fl[4] = 1'b0;
        4'hB: fl[4] = 1'b1;
        4'hC: cn = 2'b00;
        4'hD: cn[1] = 1'b1;
        4'hE: cn[0] = 1'b1;
        default: ;
      endcase
      chk({msv_o, ms_o}, {1'b1, m[2:0] == 3'h0 ? 7'h00
                                : 7'h01 << (m[2:0] - 3'h1)});
      chk(wr_sel_o, m[0]);
      @(posedge clk_i);
      #1;
      chk({console_o, flags_o}, {cn, fl});
    end
    wb(1'b0, 4'h8, 32'h0, q);
    chk(q, {25'h0, cn, fl});
  endtask
  task automatic t_port();
    logic [2:0] dev;
    logic       v;
    for (int op = 0; op < 4; op++) begin
      for (int hw = 0; hw < 8; hw++) begin
        dev = 3'(hw) ^ 3'h7;
        v = op == 3 ? 1'b0 : (op == 2 ? hw != 7 : hw <= 5);
        ld({4'h2, 1'b1, dev, 2'(op), 3'(hw), 10'h015});
        if (!(op == 1 && hw inside {4, 5})) begin
          chk(port_o, v ? {1'b1, dev, 2'(op), 3'(hw), dev == 3'h7}
                        : port_o & 10'h1FF);
        end
      end
    end
    chk(disk_cnt, 8'h03);
  endtask
  task automatic t_jump();
    logic [31:0] q;
    logic [15:0] jm;
    logic [2:0]  e;
    ib_set = 8'h13;
    ld({4'h0, 1'b1, 6'h2A, 3'h2, 3'h1, 2'h0, 4'hE});
    wb(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h00000013);
    ld({4'h1, 1'b1, 14'h2A00, 4'h4});
    chk(seq_o.target, 14'h2A13);
    for (int b = 0; b < 2; b++) begin
      cond_set.instruction_buffer_valid = b[0];
      jm = b[0] ? 16'h8897 : 16'h0897;
      for (int c = 0; c < 16; c++) begin
        ld({4'h1, 1'b0, 14'h0155, 4'(c)});
        e[2] = jm[c];
        e[1] = c == 12 || (c == 13 && b[0]);
        e[0] = c == 14 && b[0];
        chk({seq_o.jump, seq_o.call, seq_o.skip}, e);
      end
    end
  endtask
  task automatic t_decode();
    logic [7:0] ibv[3] = '{8'h5F, 8'h0F, 8'h3F};
    logic [4:0] osv[3] = '{5'h1F, 5'h07, 5'h1F};
    ld({4'h0, 1'b0, 6'h15, 3'h3, 1'b1, 3'h0, 1'b1, 4'hE});
    chk({micro_type_o, seq_o.target[13:8]}, {5'h10, 6'h15});
    chk({pc_o, rom_o}, {3'h5, 6'h23});
    chk({ibr_o, chb_o, mrs_o}, 3'h5);
    ld({4'h0, 1'b0, 6'h15, 3'h4, 5'h04, 4'hE});
    chk({pc_o, rom_o}, {3'h1, 6'h04});
    chk({ibr_o, chb_o, mrs_o}, 3'h0);
    // Native match, compat match, native miss
    for (int k = 0; k < 3; k++) begin
      cond_set.compat_mode = k == 1;
      ib_set = ibv[k];
      ld({4'h0, 1'b1, 6'h00, 3'h0, 1'b0, 3'h7, 1'b0, 4'hE});
      chk({chb_o, rd_o}, {1'b1, k != 2});
      chk(os_o, osv[k]);
    end
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    logic [31:0] q;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 4'h0, 32'h00123456, q);
    wb(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h00800000);
    wb(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0);
    t_memreq();
    t_misc();
    t_port();
    t_jump();
    t_decode();
    results();
  end
endmodule
`default_nettype wire
